// [core/umc_pkg.sv]
package umc_pkg;
	localparam logic [3:0] UMC_OFS_MODE_A = 4'h0;
	localparam logic [3:0] UMC_OFS_MODE_B = 4'h4;
	localparam int UMC_PER_HI = 31;
	localparam int UMC_PER_LO = 24;
	localparam int UMC_EN_BIT = 23;
	localparam int UMC_AM_HI = 22;
	localparam int UMC_AM_LO = 20;
	localparam int UMC_DS_HI = 18;
	localparam int UMC_DS_LO = 17;
	localparam int UMC_G0_HI = 15;
	localparam int UMC_G0_LO = 13;
	localparam int UMC_DIS_BIT = 12;
	localparam int UMC_RLF_HI = 11;
	localparam int UMC_RLF_LO = 8;
	localparam int UMC_WLF_HI = 7;
	localparam int UMC_WLF_LO = 4;
	localparam int UMC_TLF_HI = 3;
	localparam int UMC_TLF_LO = 0;
	// Reserved bits 12 and 15 in big-endian numbering read as zero
	localparam logic [31:0] UMC_MODE_WMASK = 32'hFFF6_FFFF;
	localparam logic [31:0] UMC_MODE_RST = 32'h0000_1000;
	localparam logic [4:0] UMC_A12_BIT = 5'h13;
	localparam logic [4:0] UMC_ROW_SHIFT = 5'h08;
	localparam logic [7:0] UMC_PER_ONE = 8'h01;
	localparam logic [4:0] UMC_LOOP_ONE = 5'h01;
	localparam logic [2:0] UMC_DIS_ONE = 3'h1;

	typedef enum logic [1:0] {
		UMC_PAT_READ = 2'h0,
		UMC_PAT_WRITE = 2'h1,
		UMC_PAT_TIMER = 2'h2
	} umc_pat_t;

	typedef struct packed {
		logic [1:0][31:0] mode;
		logic [1:0][7:0] ptmr;
		logic [1:0] svc;
		logic [1:0][4:0] loop;
		logic [1:0][2:0] dis;
		logic [1:0][2:0] dis_bank;
		logic [1:0] l4;
		logic [1:0] dly;
		logic [1:0] wt;
		logic gl0;
		logic [31:0] apin;
		logic [31:0] rdata;
	} umc_state_t;
endpackage

// [core/umc_ctl.sv]
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RL1: A pin: line4 output or wait, reset wait
// RL2: A dual bits: delay/wait or line4 timing
// RL3: A read loop count, zero means sixteen
// RL4: A write loop count, zero means sixteen
// RL5: A timer loop count, zero means sixteen
// RL6: B period is count of prescaled ticks
// RL7: B timer requests only when enabled, reset off
// RL8: B mux size shapes multiplexed address output
// RL9: Software writes zero to reserved bits
// RL10: Disable gap one to four cycles
// RL11: Same bank blocked until disable timer expires
// RL12: Patterns should outlast the disable period
// RL13: Line zero carries selected address bit A12..A5
// RL14: B pin: line4 output or wait, reset wait
// RL15: B dual bits: delay/wait or line4 timing
// RL16: B read loop count, zero means sixteen
// RL17: B write loop count, zero means sixteen
// RL18: B timer loop count, zero means sixteen
// RL19: A timer requests only when enabled, reset off
// RL20: Timer expiry posts request and reloads
// RL21: Loop counter loads per type, decrements
module umc_ctl import umc_pkg::*; (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	input wire logic timer_prescaled_clock_i,
	output logic [1:0] svc_req_o,
	input wire logic [1:0] pat_start_i,
	input wire logic [1:0][1:0] pat_type_i,
	input wire logic [1:0] loop_end_i,
	output logic [1:0] loop_repeat_o,
	input wire logic [1:0] disable_timer_start_i,
	input wire logic [1:0][2:0] start_bank_i,
	input wire logic [1:0][2:0] req_bank_i,
	output logic [1:0] dis_busy_o,
	output logic [1:0] bank_blocked_o,
	input wire logic acc_valid_i,
	input wire logic acc_mach_i,
	input wire logic [31:0] acc_addr_i,
	input wire logic mux_row_i,
	output logic general_line_zero_o,
	output logic [31:0] addr_pin_o,
	input wire logic [1:0] line4_timing_late_i,
	input wire logic [1:0] line4_timing_early_i,
	input wire logic [1:0] wait_input_i,
	output logic [1:0] gen_line4_o,
	output logic [1:0] gen_line4_oe_o,
	output logic [1:0] wait_hold_o,
	output logic [1:0] delay_timing_o
);
	umc_state_t state_reg;
	umc_state_t state_next;
	logic [2:0] g0_sel;
	logic [2:0] am_sel;
	logic [3:0] fld;

	always_comb begin
		state_next = state_reg;
		state_next.svc = '0;
		state_next.rdata = '0;
		g0_sel = '0;
		am_sel = '0;
		fld = '0;
		// Reserved bits are dropped on write
		if (reg_wr_i && reg_addr_i == UMC_OFS_MODE_A) begin
			state_next.mode[0] = reg_wdata_i & UMC_MODE_WMASK; // [RL9]
		end
		if (reg_wr_i && reg_addr_i == UMC_OFS_MODE_B) begin
			state_next.mode[1] = reg_wdata_i & UMC_MODE_WMASK; // [RL9]
		end
		if (reg_rd_i) begin
			if (reg_addr_i == UMC_OFS_MODE_A) begin
				state_next.rdata = state_reg.mode[0];
			end else if (reg_addr_i == UMC_OFS_MODE_B) begin
				state_next.rdata = state_reg.mode[1];
			end
		end
		for (int m = 0; m < 2; m++) begin
			// Periodic timer, one step per prescaled tick
			if (!state_reg.mode[m][UMC_EN_BIT]) begin
				state_next.ptmr[m] = state_reg.mode[m][UMC_PER_HI:UMC_PER_LO]; // [RL7] [RL19]
			end else if (timer_prescaled_clock_i) begin
				if (state_reg.ptmr[m] <= UMC_PER_ONE) begin
					state_next.svc[m] = 1'b1; // [RL20]
					state_next.ptmr[m] = state_reg.mode[m][UMC_PER_HI:UMC_PER_LO]; // [RL6]
				end else begin
					state_next.ptmr[m] = state_reg.ptmr[m] - UMC_PER_ONE; // [RL6]
				end
			end
			// Loop counter; code zero loads sixteen
			if (pat_start_i[m]) begin
				unique case (pat_type_i[m])
					UMC_PAT_READ: fld = state_reg.mode[m][UMC_RLF_HI:UMC_RLF_LO]; // [RL3] [RL16]
					UMC_PAT_WRITE: fld = state_reg.mode[m][UMC_WLF_HI:UMC_WLF_LO]; // [RL4] [RL17]
					UMC_PAT_TIMER: fld = state_reg.mode[m][UMC_TLF_HI:UMC_TLF_LO]; // [RL5] [RL18]
					default: fld = state_reg.mode[m][UMC_RLF_HI:UMC_RLF_LO];
				endcase
				state_next.loop[m] = {fld == 4'h0, fld}; // [RL21]
			end else if (loop_end_i[m] && state_reg.loop[m] != 5'h00) begin
				state_next.loop[m] = state_reg.loop[m] - UMC_LOOP_ONE; // [RL21]
			end
			// Disable timer holds off the started bank
			if (disable_timer_start_i[m]) begin
				state_next.dis[m] = {1'b0, state_reg.mode[m][UMC_DS_HI:UMC_DS_LO]} + UMC_DIS_ONE; // [RL10]
				state_next.dis_bank[m] = start_bank_i[m]; // [RL11]
			end else if (state_reg.dis[m] != 3'h0) begin
				state_next.dis[m] = state_reg.dis[m] - UMC_DIS_ONE; // [RL10]
			end
			// Shared pin: wait input or general line 4
			if (state_reg.mode[m][UMC_DIS_BIT]) begin
				state_next.l4[m] = 1'b0;
				state_next.dly[m] = line4_timing_late_i[m]; // [RL2] [RL15]
				state_next.wt[m] = line4_timing_early_i[m] & wait_input_i[m]; // [RL2] [RL15]
			end else begin
				state_next.l4[m] = line4_timing_early_i[m] | line4_timing_late_i[m]; // [RL2] [RL15]
				state_next.dly[m] = 1'b0;
				state_next.wt[m] = 1'b0;
			end
		end
		if (acc_valid_i) begin
			g0_sel = state_reg.mode[acc_mach_i][UMC_G0_HI:UMC_G0_LO];
			am_sel = state_reg.mode[acc_mach_i][UMC_AM_HI:UMC_AM_LO];
			state_next.gl0 = acc_addr_i[5'(UMC_A12_BIT + {2'h0, g0_sel})]; // [RL13]
			if (mux_row_i) begin
				state_next.apin = acc_addr_i >> 5'(UMC_ROW_SHIFT + {2'h0, am_sel}); // [RL8]
			end else begin
				state_next.apin = acc_addr_i; // [RL8]
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_reg <= '0;
			state_reg.mode[0] <= UMC_MODE_RST; // [RL1] [RL19]
			state_reg.mode[1] <= UMC_MODE_RST; // [RL14] [RL7]
		end else begin
			state_reg <= state_next;
		end
	end

	assign reg_rdata_o = state_reg.rdata;
	assign svc_req_o = state_reg.svc;
	assign general_line_zero_o = state_reg.gl0;
	assign addr_pin_o = state_reg.apin;
	assign gen_line4_o = state_reg.l4;
	assign wait_hold_o = state_reg.wt;
	assign delay_timing_o = state_reg.dly;

	for (genvar g = 0; g < 2; g++) begin : g_mach
		assign loop_repeat_o[g] = state_reg.loop[g] > UMC_LOOP_ONE; // [RL21]
		assign dis_busy_o[g] = state_reg.dis[g] != 3'h0;
		assign bank_blocked_o[g] = dis_busy_o[g]
			&& req_bank_i[g] == state_reg.dis_bank[g]; // [RL11]
		assign gen_line4_oe_o[g] = !state_reg.mode[g][UMC_DIS_BIT]; // [RL1] [RL14]
	end

	// Pin direction follows the disable bit
	AST_A_PIN_MODE: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RL1]
		reg_wr_i && reg_addr_i == UMC_OFS_MODE_A
		|=> gen_line4_oe_o[0] == !$past(reg_wdata_i[UMC_DIS_BIT]))
		else $error("machine A pin direction wrong after write");

	AST_B_PIN_MODE: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RL14]
		reg_wr_i && reg_addr_i == UMC_OFS_MODE_B
		|=> gen_line4_oe_o[1] == !$past(reg_wdata_i[UMC_DIS_BIT]))
		else $error("machine B pin direction wrong after write");

	AST_RSV_ZERO: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RL9]
		!reg_rdata_o[19] && !reg_rdata_o[16])
		else $error("reserved mode bits read back set");

	// Timers
	AST_B_REQ_ENABLED: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RL7]
		svc_req_o[1] |-> $past(state_reg.mode[1][UMC_EN_BIT]))
		else $error("timer B request while disabled");

	AST_A_REQ_ENABLED: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RL19]
		svc_req_o[0] |-> $past(state_reg.mode[0][UMC_EN_BIT]))
		else $error("timer A request while disabled");

	AST_TMR_EXPIRE: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RL20]
		state_reg.mode[1][UMC_EN_BIT] && timer_prescaled_clock_i && state_reg.ptmr[1] == 8'h01
		&& state_reg.mode[1][UMC_PER_HI:UMC_PER_LO] > 8'h01
		|=> svc_req_o[1] ##1 !svc_req_o[1])
		else $error("timer B expiry did not post one request");

	AST_A_TMR_EXPIRE: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RL20]
		state_reg.mode[0][UMC_EN_BIT] && timer_prescaled_clock_i && state_reg.ptmr[0] == 8'h01
		&& state_reg.mode[0][UMC_PER_HI:UMC_PER_LO] > 8'h01
		|=> svc_req_o[0] ##1 !svc_req_o[0])
		else $error("timer A expiry did not post one request");

	AST_A_TICK_ONLY: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RL6]
		!timer_prescaled_clock_i |=> !svc_req_o[0])
		else $error("timer A request without a tick");

	AST_B_TICK_ONLY: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RL6]
		!timer_prescaled_clock_i |=> !svc_req_o[1])
		else $error("timer B request without a tick");

	// Loop counters
	AST_LOOP_SIXTEEN: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RL3]
		pat_start_i[0] && pat_type_i[0] == UMC_PAT_READ
		&& state_reg.mode[0][UMC_RLF_HI:UMC_RLF_LO] == 4'h0
		|=> state_reg.loop[0] == 5'h10 && loop_repeat_o[0])
		else $error("read loop code zero not sixteen");

	AST_A_WRITE_SIXTEEN: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RL4]
		pat_start_i[0] && pat_type_i[0] == UMC_PAT_WRITE
		&& state_reg.mode[0][UMC_WLF_HI:UMC_WLF_LO] == 4'h0
		|=> state_reg.loop[0] == 5'h10)
		else $error("machine A write loop code zero not sixteen");

	AST_A_TIMER_SIXTEEN: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RL5]
		pat_start_i[0] && pat_type_i[0] == UMC_PAT_TIMER
		&& state_reg.mode[0][UMC_TLF_HI:UMC_TLF_LO] == 4'h0
		|=> state_reg.loop[0] == 5'h10)
		else $error("machine A timer loop code zero not sixteen");

	AST_B_READ_SIXTEEN: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RL16]
		pat_start_i[1] && pat_type_i[1] == UMC_PAT_READ
		&& state_reg.mode[1][UMC_RLF_HI:UMC_RLF_LO] == 4'h0
		|=> state_reg.loop[1] == 5'h10)
		else $error("machine B read loop code zero not sixteen");

	AST_B_WRITE_LOAD: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RL17]
		pat_start_i[1] && pat_type_i[1] == UMC_PAT_WRITE
		|=> state_reg.loop[1][3:0] == $past(state_reg.mode[1][UMC_WLF_HI:UMC_WLF_LO]))
		else $error("machine B write loop not loaded from its field");

	AST_B_TIMER_LOAD: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RL18]
		pat_start_i[1] && pat_type_i[1] == UMC_PAT_TIMER
		|=> state_reg.loop[1][3:0] == $past(state_reg.mode[1][UMC_TLF_HI:UMC_TLF_LO]))
		else $error("machine B timer loop not loaded from its field");

	AST_A_LOOP_STEP: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RL21]
		!pat_start_i[0] && loop_end_i[0] && state_reg.loop[0] != 5'h00
		|=> state_reg.loop[0] == $past(state_reg.loop[0]) - UMC_LOOP_ONE)
		else $error("machine A loop counter did not step down");

	// Disable timers
	AST_DIS_FOUR: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RL10]
		disable_timer_start_i[1] && state_reg.mode[1][UMC_DS_HI:UMC_DS_LO] == 2'h3
		##1 !disable_timer_start_i[1] [*4]
		|-> $past(dis_busy_o[1], 3) && dis_busy_o[1] ##1 !dis_busy_o[1])
		else $error("disable period code 3 not four cycles");

	AST_DIS_ONE: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RL11]
		disable_timer_start_i[1] && state_reg.mode[1][UMC_DS_HI:UMC_DS_LO] == 2'h0
		##1 !disable_timer_start_i[1]
		|-> bank_blocked_o[1] == (req_bank_i[1] == $past(start_bank_i[1]))
		##1 (disable_timer_start_i[1] || !dis_busy_o[1]))
		else $error("disable period code 0 not one cycle");

	AST_A_DIS_START: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RL10]
		disable_timer_start_i[0] |=> dis_busy_o[0])
		else $error("machine A disable timer did not start");

	AST_A_BANK_BLOCK: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RL11]
		disable_timer_start_i[0] ##1 req_bank_i[0] == $past(start_bank_i[0])
		|-> bank_blocked_o[0])
		else $error("machine A same bank not blocked");

	// Line zero and address pins
	AST_LINE0_BIT: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RL13]
		acc_valid_i && acc_mach_i && state_reg.mode[1][UMC_G0_HI:UMC_G0_LO] == 3'h7
		|=> general_line_zero_o == $past(acc_addr_i[26]))
		else $error("line zero not A5 for code 7");

	AST_A_LINE0_A12: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RL13]
		acc_valid_i && !acc_mach_i && state_reg.mode[0][UMC_G0_HI:UMC_G0_LO] == 3'h0
		|=> general_line_zero_o == $past(acc_addr_i[19]))
		else $error("line zero not A12 for code 0");

	AST_ADDR_FLAT: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RL8]
		acc_valid_i && !mux_row_i |=> addr_pin_o == $past(acc_addr_i))
		else $error("plain address not passed to pins");

	AST_ADDR_HOLD: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RL8]
		!acc_valid_i |=> $stable(addr_pin_o))
		else $error("address pins moved without an access");

	// Shared pins
	AST_WAIT_HOLD: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RL15]
		state_reg.mode[1][UMC_DIS_BIT] && line4_timing_early_i[1] && wait_input_i[1]
		|=> wait_hold_o[1] && !gen_line4_o[1])
		else $error("wait enable ignored on machine B");

	AST_B_DELAY: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RL15]
		state_reg.mode[1][UMC_DIS_BIT] && line4_timing_late_i[1]
		|=> delay_timing_o[1])
		else $error("delay bit ignored on machine B");

	AST_B_LINE4_OUT: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RL15]
		!state_reg.mode[1][UMC_DIS_BIT] && line4_timing_late_i[1]
		|=> gen_line4_o[1] && !delay_timing_o[1])
		else $error("machine B line 4 output wrong");

	AST_A_WAIT_HOLD: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RL2]
		state_reg.mode[0][UMC_DIS_BIT] && line4_timing_early_i[0] && wait_input_i[0]
		|=> wait_hold_o[0] && !gen_line4_o[0])
		else $error("wait enable ignored on machine A");

	AST_A_LINE4_OUT: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [RL2]
		!state_reg.mode[0][UMC_DIS_BIT] && line4_timing_early_i[0]
		|=> gen_line4_o[0] && !wait_hold_o[0])
		else $error("machine A line 4 output wrong");
endmodule
`default_nettype wire

// [test/umc_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module umc_mem_model (
	input wire logic [1:0] line4_i,
	input wire logic [1:0] line4_oe_i,
	input wire logic slow_i,
	output logic [1:0] wait_o
);
	// Shared pin level: device drive when enabled, else memory wait
	always_comb begin
		for (int m = 0; m < 2; m++) begin
			wait_o[m] = line4_oe_i[m] ? line4_i[m] : slow_i;
		end
	end
endmodule
`default_nettype wire

// [test/umc_ctl_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module umc_ctl_tb import umc_pkg::*;;
	logic clk_sys_i = 1'b0;
	logic rstn_i = 1'b0;
	logic rwr = 1'b0, rrd = 1'b0, tick = 1'b0, av = 1'b0, am = 1'b0, mr = 1'b0;
	logic [3:0] ad = 4'h0;
	logic [31:0] wd = 32'h0, aa = 32'h0, rdat, apin;
	logic [1:0] ps = 2'h0, le = 2'h0, ds = 2'h0, late = 2'h0, early = 2'h0;
	logic [1:0][1:0] pt = 4'h0;
	logic [1:0][2:0] sb = 6'h00, rb = 6'h00;
	logic [1:0] svc, rep, busy, blk, wi, l4, oe, wh, dly;
	logic gl0;
	logic slow = 1'b1;
	int num_errors = 0;
	int check_count = 0;
	always #50 clk_sys_i = ~clk_sys_i;
	umc_ctl dut_u (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .reg_addr_i(ad), .reg_wdata_i(wd),
		.reg_wr_i(rwr), .reg_rd_i(rrd), .reg_rdata_o(rdat), .timer_prescaled_clock_i(tick),
		.svc_req_o(svc), .pat_start_i(ps), .pat_type_i(pt), .loop_end_i(le), .loop_repeat_o(rep),
		.disable_timer_start_i(ds), .start_bank_i(sb), .req_bank_i(rb), .dis_busy_o(busy),
		.bank_blocked_o(blk), .acc_valid_i(av), .acc_mach_i(am), .acc_addr_i(aa), .mux_row_i(mr),
		.general_line_zero_o(gl0), .addr_pin_o(apin), .line4_timing_late_i(late),
		.line4_timing_early_i(early), .wait_input_i(wi), .gen_line4_o(l4), .gen_line4_oe_o(oe),
		.wait_hold_o(wh), .delay_timing_o(dly));
	umc_mem_model mem_u (.line4_i(l4), .line4_oe_i(oe), .slow_i(slow), .wait_o(wi));
	task chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task wr_t(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys_i) begin ad <= a; wd <= d; rwr <= 1'b1; end
		@(posedge clk_sys_i) rwr <= 1'b0;
	endtask
	task rd_t(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk_sys_i) begin ad <= a; rrd <= 1'b1; end
		@(posedge clk_sys_i) rrd <= 1'b0;
		#1 chk(rdat, e);
	endtask
	task lp(input int m, input logic [1:0] ty, input logic [3:0] c);
		int n;
		wr_t(m ? 4'h4 : 4'h0, {20'h00001, c, c, c});
		@(posedge clk_sys_i) begin ps[m] <= 1'b1; pt[m] <= ty; end
		@(posedge clk_sys_i) ps[m] <= 1'b0;
		#1 n = 1;
		while (rep[m] === 1'b1 && n < 20) begin
			@(posedge clk_sys_i) le[m] <= 1'b1;
			@(posedge clk_sys_i) le[m] <= 1'b0;
			#1 n++;
		end
		chk(n, (c == 4'h0) ? 16 : c);
	endtask
	task wsvc(input int m, output int c);
		c = 0;
		do begin
			@(posedge clk_sys_i);
			#1 c++;
		end while (svc[m] !== 1'b1 && c < 50);
	endtask
	task print_verdict;
		$display("errors=%0d checks=%0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		int n;
		logic [31:0] a;
		repeat (6) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		rd_t(4'h0, 32'h0000_1000);
		rd_t(4'h4, 32'h0000_1000);
		chk(oe, 2'h0);
		wr_t(4'h0, 32'hFFFF_FFFF);
		rd_t(4'h0, 32'hFFF6_FFFF);
		rd_t(4'h8, 32'h0000_0000);
		wr_t(4'h0, 32'h0000_1000);
		for (int m = 0; m < 2; m++) begin
			for (int t = 0; t < 3; t++) begin
				lp(m, t[1:0], 4'h1);
				lp(m, t[1:0], 4'hF);
				lp(m, t[1:0], 4'h0);
			end
		end
		wr_t(4'h4, 32'h0380_1000);
		@(posedge clk_sys_i) tick <= 1'b1;
		wsvc(1, n);
		chk(svc[1], 1'b1);
		wsvc(1, n);
		chk(n, 3);
		wr_t(4'h4, 32'h0300_1000);
		wsvc(1, n);
		chk(n, 50);
		wr_t(4'h0, 32'h0280_1000);
		wsvc(0, n);
		chk(svc[0], 1'b1);
		wsvc(0, n);
		chk(n, 2);
		wr_t(4'h0, 32'h0000_1000);
		@(posedge clk_sys_i) tick <= 1'b0;
		for (int d = 0; d < 4; d++) begin
			wr_t(4'h4, 32'h0000_1000 | (d << 17));
			@(posedge clk_sys_i) begin ds[1] <= 1'b1; sb[1] <= 3'h5; rb[1] <= (d == 3) ? 3'h2 : 3'h5; end
			@(posedge clk_sys_i) ds[1] <= 1'b0;
			#1 n = 0;
			while (busy[1] === 1'b1 && n < 9) begin
				chk(blk[1], d != 3);
				@(posedge clk_sys_i);
				#1 n++;
			end
			chk(n, d + 1);
		end
		for (int c = 0; c < 8; c++) begin
			a = 32'h1 << (19 + c);
			wr_t(4'h4, 32'h0000_1000 | (c << 20) | (c << 13));
			@(posedge clk_sys_i) begin av <= 1'b1; am <= 1'b1; aa <= a; mr <= c[0]; end
			@(posedge clk_sys_i) av <= 1'b0;
			#1 chk(gl0, 1'b1);
			chk(apin, c[0] ? a >> (8 + c) : a);
			@(posedge clk_sys_i) begin av <= 1'b1; aa <= ~a; end
			@(posedge clk_sys_i) av <= 1'b0;
			#1 chk(gl0, 1'b0);
		end
		wr_t(4'h4, 32'h0000_0000);
		@(posedge clk_sys_i) begin early <= 2'h3; late <= 2'h1; end
		@(posedge clk_sys_i);
		#1 chk({oe, l4[1], wh, dly[0]}, 6'h2B);
		@(posedge clk_sys_i) slow <= 1'b0;
		@(posedge clk_sys_i);
		#1 chk(wh, 2'h0);
		print_verdict();
	end
endmodule
`default_nettype wire
